// [flash_clear_pkg.sv]
package flash_clear_pkg;

    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int unsigned CLK_PERIOD_NS      = 10;
    localparam int unsigned PAGE_CLEAR_TIME_US = 10000;
    localparam int unsigned SMALL_CLEAR_TIME_US = 150000;
    localparam int unsigned BIG_CLEAR_TIME_US  = 1000000;
    localparam int unsigned ARRAY_CLEAR_TIME_US = 2000000;
    localparam int unsigned SLEEP_ENTRY_NS     = 3000;
    localparam int unsigned SLEEP_EXIT_NS      = 30000;
    localparam int unsigned PAGE_CLEAR_CYC  = PAGE_CLEAR_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned SMALL_CLEAR_CYC = SMALL_CLEAR_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned BIG_CLEAR_CYC   = BIG_CLEAR_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned ARRAY_CLEAR_CYC = ARRAY_CLEAR_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SLEEP_EXIT_CYC  = (SLEEP_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------
    // Command codes
    // ----------------------------------------
    localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
    localparam logic [7:0] OP_PAGE_CLEAR   = 8'hDB;
    localparam logic [7:0] OP_SMALL_CLEAR  = 8'h20;
    localparam logic [7:0] OP_BIG_CLEAR    = 8'hD8;
    localparam logic [7:0] OP_ARRAY_CLEAR  = 8'hC7;
    localparam logic [7:0] OP_SLEEP_ENTER  = 8'hB9;
    localparam logic [7:0] OP_SLEEP_EXIT   = 8'hAB;

    // ----------------------------------------
    // Frame and address layout
    // ----------------------------------------
    localparam int unsigned ADDR_W      = 24;
    localparam int unsigned CNT_W       = 6;
    localparam logic [5:0]  OPCODE_BITS = 6'h08;
    localparam logic [5:0]  ADDR_FRAME_BITS = 6'h20;
    localparam int unsigned PAGE_SHIFT  = 8;
    localparam int unsigned SMALL_SHIFT = 12;
    localparam int unsigned BIG_SHIFT   = 16;
    localparam int unsigned MEM_ADDR_BITS_2M = 18;
    localparam logic [7:0]  ERASED_BYTE = 8'hFF;

    typedef enum logic [1:0] {
        CK_PAGE  = 2'h0,
        CK_SMALL = 2'h1,
        CK_BIG   = 2'h2,
        CK_ARRAY = 2'h3
    } clear_kind_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ENTER = 3'h1,
        ST_SLEEP = 3'h3,
        ST_EXIT  = 3'h2,
        ST_CLEAR = 3'h6
    } dev_state_t;

endpackage : flash_clear_pkg

// [spi_frame_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface spi_frame_if;
    logic        frame_end;
    logic [5:0]  bits;
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic        selected;

    modport rx   (output frame_end, output bits, output opcode, output addr, output selected);
    modport core (input frame_end, input bits, input opcode, input addr, input selected);
endinterface : spi_frame_if
`default_nettype wire

// [spi_frame_rx.sv]
`timescale 1ns/100ps
`default_nettype none
module spi_frame_rx
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Serial pins
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic mosi,
    // Frame summary
    spi_frame_if.rx   fr
);
    import flash_clear_pkg::*;

    logic [2:0]  sclk_sync_ff;
    logic [2:0]  cs_sync_ff;
    logic [1:0]  mosi_sync_ff;
    logic [5:0]  bits_ff;
    logic [31:0] shift_ff;
    logic [7:0]  opcode_ff;
    logic        frame_end_ff;
    logic [5:0]  end_bits_ff;
    logic [23:0] end_addr_ff;
    logic        sclk_rise;
    logic        cs_rise;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sclk_sync_ff <= 3'h0;
            cs_sync_ff   <= 3'h7;
            mosi_sync_ff <= 2'h0;
        end
        else
        begin
            sclk_sync_ff <= {sclk_sync_ff[1:0], sclk};
            cs_sync_ff   <= {cs_sync_ff[1:0], cs_n};
            mosi_sync_ff <= {mosi_sync_ff[0], mosi};
        end
    end

    // Edges seen on stages two and three only
    assign sclk_rise = sclk_sync_ff[1] & ~sclk_sync_ff[2] & ~cs_sync_ff[1];
    assign cs_rise   = cs_sync_ff[1] & ~cs_sync_ff[2];

    // ----------------------------------------
    // Bit shifting, MSB first on rising clock
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst || cs_sync_ff[1])
        begin
            bits_ff  <= 6'h00;
        end
        else if (sclk_rise)
        begin
            bits_ff  <= (bits_ff == 6'h3F) ? bits_ff : bits_ff + 6'h01; // RQ25
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            shift_ff  <= 32'h0;
            opcode_ff <= 8'h00;
        end
        else if (sclk_rise)
        begin
            shift_ff <= {shift_ff[30:0], mosi_sync_ff[1]}; // RQ25
            if (bits_ff == OPCODE_BITS - 6'h01)
            begin
                opcode_ff <= {shift_ff[6:0], mosi_sync_ff[1]};
            end
        end
    end

    // Frame summary frozen at deselect so the core sees a stable count
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            frame_end_ff <= 1'b0;
            end_bits_ff  <= 6'h00;
            end_addr_ff  <= 24'h000000;
        end
        else
        begin
            frame_end_ff <= cs_rise;
            if (cs_rise)
            begin
                end_bits_ff <= bits_ff;
                end_addr_ff <= shift_ff[23:0];
            end
        end
    end

    assign fr.frame_end = frame_end_ff;
    assign fr.bits      = end_bits_ff;
    assign fr.opcode    = opcode_ff;
    assign fr.addr      = end_addr_ff;
    assign fr.selected  = ~cs_sync_ff[1];

endmodule : spi_frame_rx
`default_nettype wire

// [flash_clear_ctrl.sv]
// Overview of operation
// [RQ1] Page clear fills addressed page with ones
// [RQ2] Clears need write unlock latch set first
// [RQ3] Master sends opcode then three address bytes
// [RQ4] Low address bits inside region are ignored
// [RQ5] Master keeps select low whole command
// [RQ6] Addressed clear needs exactly 32 bits
// [RQ7] Valid clear starts timed cycle per kind
// [RQ8] Busy flag high during cycle, then low
// [RQ9] Unlock latch drops during the clear cycle
// [RQ10] Page clear refused in hardware protected area
// [RQ11] Small block refused if any page protected
// [RQ12] Big block refused if hardware protected page
// [RQ13] Commands rejected while any cycle runs
// [RQ14] Upper address bits beyond memory size ignored
// [RQ15] Array clear is opcode only, 8 bits
// [RQ16] Array clear refused if anything protected
// [RQ17] Reset pin low aborts the running cycle
// [RQ18] Deselect gives standby only when idle
// [RQ19] Sleep entry opcode only, then delayed entry
// [RQ20] Sleep ignores all but sleep exit
// [RQ21] Power-up always lands in standby
// [RQ22] Sleep exit with extra clocks is rejected
// [RQ23] Standby returns after sleep exit delay
// [RQ24] Power-up clears busy and unlock latch
// [RQ25] Bytes shift MSB first on rising clock
`timescale 1ns/100ps
`default_nettype none
module flash_clear_ctrl
#(
    parameter int unsigned MEM_ADDR_BITS   = flash_clear_pkg::MEM_ADDR_BITS_2M,
    parameter int unsigned PAGE_CLEAR_CYC  = flash_clear_pkg::PAGE_CLEAR_CYC,
    parameter int unsigned SMALL_CLEAR_CYC = flash_clear_pkg::SMALL_CLEAR_CYC,
    parameter int unsigned BIG_CLEAR_CYC   = flash_clear_pkg::BIG_CLEAR_CYC,
    parameter int unsigned ARRAY_CLEAR_CYC = flash_clear_pkg::ARRAY_CLEAR_CYC,
    parameter int unsigned SLEEP_ENTRY_CYC = flash_clear_pkg::SLEEP_ENTRY_CYC,
    parameter int unsigned SLEEP_EXIT_CYC  = flash_clear_pkg::SLEEP_EXIT_CYC,
    parameter int unsigned SECTORS         = 1 << (MEM_ADDR_BITS - flash_clear_pkg::BIG_SHIFT)
)
(
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst,
    // Serial link pins and reset pin
    input  wire logic                         sclk,
    input  wire logic                         cs_n,
    input  wire logic                         mosi,
    input  wire logic                         reset_pin_n,
    // Protection and other cycles
    input  wire logic [1:0]                   hw_prot_level,
    input  wire logic [SECTORS-1:0]           sw_lock,
    input  wire logic                         write_cycle_active,
    // Status
    output logic                              busy_flag,
    output logic                              write_unlock_latch,
    output logic                              sleep_mode,
    output logic                              standby,
    // Clear request, all four kinds
    output logic                              clear_go,
    output flash_clear_pkg::clear_kind_t      clear_kind,
    output logic [flash_clear_pkg::ADDR_W-1:0] clear_base,
    output logic [7:0]                        clear_fill,
    output logic                              clear_done,
    output logic                              clear_abort
);
    import flash_clear_pkg::*;

    spi_frame_if fr ();

    logic [1:0]        rpin_sync_ff;
    logic              reset_low;
    dev_state_t        state_ff;
    dev_state_t        nxt_state;
    logic [31:0]       timer_ff;
    logic [31:0]       nxt_timer;
    logic              busy_flag_ff;
    logic              unlock_latch_ff;
    logic              sleep_mode_ff;
    logic              standby_ff;
    logic              clear_go_ff;
    clear_kind_t       clear_kind_ff;
    logic [ADDR_W-1:0] clear_base_ff;
    logic              clear_done_ff;
    logic              clear_abort_ff;
    logic              accept_clear;
    logic              accept_unlock;
    clear_kind_t       nxt_kind;
    logic [ADDR_W-1:0] nxt_base;
    logic [31:0]       nxt_len;

    spi_frame_rx u_rx
    (
        .clk  (clk),
        .rst  (rst),
        .sclk (sclk),
        .cs_n (cs_n),
        .mosi (mosi),
        .fr   (fr)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic is_cmd(input logic [7:0] op, input logic [5:0] nbits);
        is_cmd = fr.frame_end && (fr.opcode == op) && (fr.bits == nbits);
    endfunction : is_cmd

    // Region base: drop bits above the array and below the region size
    function automatic logic [ADDR_W-1:0] region_base(input logic [ADDR_W-1:0] a,
                                                      input int unsigned sh);
        logic [ADDR_W-1:0] keep;
        keep = ADDR_W'((25'h1 << MEM_ADDR_BITS) - 25'h1); // RQ14
        region_base = (a & keep) & ~ADDR_W'((25'h1 << sh) - 25'h1); // RQ4
    endfunction : region_base

    // Hardware area is the top 1/4, 1/2 or all of the array
    function automatic logic hw_hit(input logic [ADDR_W-1:0] base, input int unsigned sh);
        logic [24:0] mem;
        logic [24:0] start;
        logic [24:0] last;
        mem    = 25'h1 << MEM_ADDR_BITS;
        start  = mem - (mem >> (2'h3 - hw_prot_level));
        last   = {1'b0, base} | ((25'h1 << sh) - 25'h1);
        hw_hit = (hw_prot_level != 2'h0) && (last >= start);
    endfunction : hw_hit

    function automatic logic sw_hit(input logic [ADDR_W-1:0] base);
        int unsigned idx;
        idx    = int'(base >> BIG_SHIFT);
        sw_hit = (idx < SECTORS) ? sw_lock[idx] : 1'b0;
    endfunction : sw_hit

    // ----------------------------------------
    // Reset pin synchroniser
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rpin_sync_ff <= 2'h3;
        end
        else
        begin
            rpin_sync_ff <= {rpin_sync_ff[0], reset_pin_n};
        end
    end

    assign reset_low = ~rpin_sync_ff[1];

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    // Only an idle device takes commands; any cycle here or elsewhere blocks them
    always_comb
    begin
        accept_clear  = 1'b0;
        nxt_kind      = CK_PAGE;
        nxt_base      = region_base(fr.addr, PAGE_SHIFT);
        nxt_len       = PAGE_CLEAR_CYC;
        accept_unlock = (state_ff == ST_IDLE) && !write_cycle_active
                        && is_cmd(OP_WRITE_UNLOCK, OPCODE_BITS);
        if ((state_ff == ST_IDLE) && !write_cycle_active && unlock_latch_ff) // RQ13 RQ2
        begin
            if (is_cmd(OP_PAGE_CLEAR, ADDR_FRAME_BITS)) // RQ6
            begin
                accept_clear = !hw_hit(nxt_base, PAGE_SHIFT); // RQ10
            end
            else if (is_cmd(OP_SMALL_CLEAR, ADDR_FRAME_BITS))
            begin
                nxt_kind     = CK_SMALL;
                nxt_base     = region_base(fr.addr, SMALL_SHIFT);
                nxt_len      = SMALL_CLEAR_CYC;
                accept_clear = !hw_hit(nxt_base, SMALL_SHIFT) && !sw_hit(nxt_base); // RQ11
            end
            else if (is_cmd(OP_BIG_CLEAR, ADDR_FRAME_BITS))
            begin
                nxt_kind     = CK_BIG;
                nxt_base     = region_base(fr.addr, BIG_SHIFT);
                nxt_len      = BIG_CLEAR_CYC;
                accept_clear = !hw_hit(nxt_base, BIG_SHIFT); // RQ12
            end
            else if (is_cmd(OP_ARRAY_CLEAR, OPCODE_BITS)) // RQ15
            begin
                nxt_kind     = CK_ARRAY;
                nxt_base     = {ADDR_W{1'b0}};
                nxt_len      = ARRAY_CLEAR_CYC;
                accept_clear = (hw_prot_level == 2'h0) && (sw_lock == '0); // RQ16
            end
        end
    end

    // ----------------------------------------
    // Mode state machine
    // ----------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        nxt_timer = (timer_ff != 32'h0) ? timer_ff - 32'h1 : 32'h0;
        case (state_ff)
            ST_IDLE:
            begin
                if (accept_clear)
                begin
                    nxt_state = ST_CLEAR; // RQ7
                    nxt_timer = nxt_len;
                end
                else if (!write_cycle_active && is_cmd(OP_SLEEP_ENTER, OPCODE_BITS)) // RQ19
                begin
                    nxt_state = ST_ENTER;
                    nxt_timer = SLEEP_ENTRY_CYC;
                end
            end
            ST_ENTER:
            begin
                if (timer_ff <= 32'h1)
                begin
                    nxt_state = ST_SLEEP; // RQ19
                end
            end
            ST_SLEEP:
            begin
                // Frames with stray clocks after the opcode count more than 8 bits
                if (is_cmd(OP_SLEEP_EXIT, OPCODE_BITS)) // RQ20 RQ22
                begin
                    nxt_state = ST_EXIT;
                    nxt_timer = SLEEP_EXIT_CYC;
                end
            end
            ST_EXIT:
            begin
                if (timer_ff <= 32'h1)
                begin
                    nxt_state = ST_IDLE; // RQ23
                end
            end
            ST_CLEAR:
            begin
                if (timer_ff <= 32'h1)
                begin
                    nxt_state = ST_IDLE; // RQ8
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
                nxt_timer = 32'h0;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst || reset_low) // RQ17 RQ21
        begin
            state_ff <= ST_IDLE;
            timer_ff <= 32'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            timer_ff <= nxt_timer;
        end
    end

    // ----------------------------------------
    // Write unlock latch
    // ----------------------------------------
    // Dropped on the first cycle of a clear; set only when idle, so no clash
    always_ff @(posedge clk)
    begin
        if (rst || reset_low) // RQ24
        begin
            unlock_latch_ff <= 1'b0;
        end
        else if (accept_unlock)
        begin
            unlock_latch_ff <= 1'b1; // RQ2
        end
        else if (state_ff == ST_CLEAR)
        begin
            unlock_latch_ff <= 1'b0; // RQ9
        end
    end

    // ----------------------------------------
    // Status and clear request outputs
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst) // RQ24 RQ21
        begin
            busy_flag_ff   <= 1'b0;
            sleep_mode_ff  <= 1'b0;
            standby_ff     <= 1'b1;
            clear_done_ff  <= 1'b0;
            clear_abort_ff <= 1'b0;
        end
        else
        begin
            busy_flag_ff   <= !reset_low && (nxt_state == ST_CLEAR); // RQ8
            sleep_mode_ff  <= !reset_low && (nxt_state == ST_SLEEP);
            standby_ff     <= (reset_low || nxt_state == ST_IDLE) && !fr.selected; // RQ18
            clear_done_ff  <= !reset_low && (state_ff == ST_CLEAR) && (nxt_state == ST_IDLE);
            clear_abort_ff <= reset_low && (state_ff == ST_CLEAR); // RQ17
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            clear_go_ff   <= 1'b0;
            clear_kind_ff <= CK_PAGE;
            clear_base_ff <= {ADDR_W{1'b0}};
        end
        else
        begin
            clear_go_ff <= accept_clear && !reset_low;
            if (accept_clear)
            begin
                clear_kind_ff <= nxt_kind;
                clear_base_ff <= nxt_base; // RQ1
            end
        end
    end

    assign busy_flag          = busy_flag_ff;
    assign write_unlock_latch = unlock_latch_ff;
    assign sleep_mode         = sleep_mode_ff;
    assign standby            = standby_ff;
    assign clear_go           = clear_go_ff;
    assign clear_kind         = clear_kind_ff;
    assign clear_base         = clear_base_ff;
    assign clear_fill         = ERASED_BYTE; // RQ1
    assign clear_done         = clear_done_ff;
    assign clear_abort        = clear_abort_ff;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_clear_start;
        clear_go_ff;
    endsequence

    sequence s_sleep_frame;
        (state_ff == ST_SLEEP) && fr.frame_end;
    endsequence

    a_page_base_aligned: assert property ( // RQ4
        s_clear_start and (clear_kind_ff == CK_PAGE) |-> (clear_base_ff[7:0] == 8'h00))
        else $error("page clear base not page aligned");
    a_latch_gates_clear: assert property ( // RQ2
        $rose(busy_flag_ff) |-> $past(unlock_latch_ff))
        else $error("clear started without unlock latch");
    a_addr_frame_len: assert property ( // RQ6
        s_clear_start and (clear_kind_ff != CK_ARRAY) |-> ($past(fr.bits) == 6'h20))
        else $error("addressed clear taken with wrong bit count");
    a_busy_on_start: assert property ( // RQ8
        s_clear_start |-> busy_flag_ff ##1 busy_flag_ff || clear_abort_ff)
        else $error("busy flag not raised by clear");
    a_latch_drops: assert property ( // RQ9
        $rose(busy_flag_ff) |=> !unlock_latch_ff)
        else $error("unlock latch kept during clear");
    a_reject_busy: assert property ( // RQ13
        busy_flag_ff && fr.frame_end |=> !clear_go_ff && (state_ff != ST_ENTER))
        else $error("command taken while busy");
    a_sleep_ignores: assert property ( // RQ20
        s_sleep_frame |=> !clear_go_ff && !$rose(unlock_latch_ff))
        else $error("command obeyed in sleep");
    a_exit_extra_clk: assert property ( // RQ22
        s_sleep_frame and (fr.bits != 6'h08) && !reset_low |=> (state_ff == ST_SLEEP))
        else $error("sleep exit taken with extra clocks");
    a_array_protect: assert property ( // RQ16
        s_clear_start and (clear_kind_ff == CK_ARRAY)
        |-> ($past(hw_prot_level) == 2'h0) && ($past(sw_lock) == '0))
        else $error("array clear despite protection");
    a_abort_reset: assert property ( // RQ17
        reset_low && busy_flag_ff |=> !busy_flag_ff && clear_abort_ff)
        else $error("reset pin did not abort clear");
    a_entry_timing: assert property ( // RQ19
        (state_ff == ST_ENTER) && (timer_ff == 32'h1) && !reset_low |=> sleep_mode_ff)
        else $error("sleep not entered after entry delay");
    a_exit_timing: assert property ( // RQ23
        (state_ff == ST_EXIT) && (timer_ff == 32'h1) && !reset_low |=> (state_ff == ST_IDLE)
        ##1 !sleep_mode_ff)
        else $error("standby not reached after exit delay");
    a_power_up: assert property (@(posedge clk) disable iff (1'b0) // RQ24
        rst |=> !busy_flag_ff && !unlock_latch_ff && !sleep_mode_ff && (state_ff == ST_IDLE))
        else $error("power-up state wrong");

endmodule : flash_clear_ctrl
`default_nettype wire

// [spi_master_model.sv]
`timescale 1ns/100ps
`default_nettype none
module spi_master_model
(
    // Clock
    input  wire logic clk,
    // Serial pins
    output var logic  sclk,
    output var logic  cs_n,
    output var logic  mosi
);
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    task automatic half;
        repeat (4) @(negedge clk);
    endtask : half

    // ----
    // Frame: b right-aligned, n bits sent, link clock idles low
    // ----
    task automatic send(input logic [39:0] b, input int n);
        cs_n = 1'b0;
        half();
        for (int i = n - 1; i >= 0; i--)
        begin
            mosi = b[i];
            half();
            sclk = 1'b1;
            half();
            sclk = 1'b0;
        end
        half();
        cs_n = 1'b1;
        // Released line must not show the last bit
        mosi = ~mosi;
        half();
    endtask : send
endmodule : spi_master_model
`default_nettype wire

// [tb_flash_clear_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_flash_clear_ctrl;
    import flash_clear_pkg::*;
    localparam int SE = 20;
    localparam int SX = 30;
    localparam logic [39:0] OPS [4] = '{40'hDBFC1234, 40'h20035678, 40'hD8035678, 40'hC7};
    localparam int NB [4] = '{32, 32, 32, 8};
    // Big clear outlasts two opcode frames so refusal while busy can be seen
    localparam int LEN [4] = '{40, 45, 400, 55};
    localparam logic [23:0] BASE [3] = '{24'h001200, 24'h035000, 24'h030000};
    logic clk, rst, sclk, cs_n, mosi, reset_pin_n, write_cycle_active;
    logic busy_flag, write_unlock_latch, sleep_mode, standby, clear_go, clear_done, clear_abort;
    logic [1:0] hw_prot_level;
    logic [3:0] sw_lock;
    logic [1:0] gkind;
    logic [23:0] clear_base, gbase;
    logic [7:0] clear_fill;
    clear_kind_t clear_kind;
    int miscompares, tests_run, ngo, nab, ndone;

    spi_master_model i_spi_master_model (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
    flash_clear_ctrl #(.MEM_ADDR_BITS(18), .PAGE_CLEAR_CYC(40), .SMALL_CLEAR_CYC(45),
        .BIG_CLEAR_CYC(400), .ARRAY_CLEAR_CYC(55), .SLEEP_ENTRY_CYC(SE), .SLEEP_EXIT_CYC(SX))
    i_flash_clear_ctrl (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .reset_pin_n(reset_pin_n), .hw_prot_level(hw_prot_level), .sw_lock(sw_lock),
        .write_cycle_active(write_cycle_active), .busy_flag(busy_flag),
        .write_unlock_latch(write_unlock_latch), .sleep_mode(sleep_mode), .standby(standby),
        .clear_go(clear_go), .clear_kind(clear_kind), .clear_base(clear_base),
        .clear_fill(clear_fill), .clear_done(clear_done), .clear_abort(clear_abort));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (clear_go === 1'b1)
        begin
            ngo++;
            gkind = clear_kind;
            gbase = clear_base;
        end
        if (clear_abort === 1'b1)
            nab++;
        if (clear_done === 1'b1)
            ndone++;
    end

    // ----
    // Tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim

    task automatic tx(input logic [39:0] b, input int n);
        i_spi_master_model.send(b, n);
        repeat (8) @(negedge clk);
    endtask : tx

    // Counts the busy cycles left; part of the cycle has passed inside tx
    task automatic run_out(input int len);
        int c;
        c = 0;
        while (busy_flag === 1'b1 && c < 2000)
        begin
            @(negedge clk);
            c++;
        end
        if (len > 0)
            chk(c >= len - 12 && c <= len - 4, 1);
    endtask : run_out

    initial
    begin
        #200000;
        miscompares++;
        end_sim();
    end

    initial
    begin
        {rst, reset_pin_n, write_cycle_active, hw_prot_level, sw_lock} = 9'h180;
        {miscompares, tests_run, ngo, nab, ndone} = '0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk({busy_flag, write_unlock_latch, sleep_mode, standby}, 4'h1);
        tx(40'hDB000000, 32);
        chk(ngo, 0);
        for (int k = 0; k < 4; k++)
        begin
            tx(40'h06, 8);
            chk(write_unlock_latch, 1);
            tx(OPS[k], NB[k]);
            chk({busy_flag, write_unlock_latch, standby}, 3'h4);
            chk({gkind, clear_fill}, {k[1:0], 8'hFF});
            if (k < 3)
                chk(gbase, BASE[k]);
            run_out(LEN[k]);
        end
        tx(40'h06, 8);
        tx({8'hDB, 23'h0}, 31);
        tx({8'hC7, 1'b0}, 9);
        chk({ngo[7:0], ndone[7:0], write_unlock_latch}, {8'd4, 8'd4, 1'b1});
        hw_prot_level = 2'h3;
        tx(40'hDB000000, 32);
        chk(ngo, 4);
        {hw_prot_level, sw_lock} = 6'h01;
        tx(40'h20000000, 32);
        tx(40'hC7, 8);
        chk(ngo, 4);
        tx(40'hD8000000, 32);
        chk({ngo[7:0], busy_flag}, {8'd5, 1'b1});
        tx(40'hB9, 8);
        tx(40'h06, 8);
        chk({sleep_mode, write_unlock_latch, busy_flag}, 3'h1);
        run_out(0);
        {sw_lock, write_cycle_active} = 5'h01;
        tx(40'hB9, 8);
        repeat (SE) @(negedge clk);
        chk(sleep_mode, 0);
        write_cycle_active = 1'b0;
        tx(40'hB9, 8);
        chk(sleep_mode, 0);
        repeat (SE) @(negedge clk);
        chk({sleep_mode, standby}, 2'h2);
        tx(40'h06, 8);
        chk(write_unlock_latch, 0);
        tx({8'hAB, 1'b0}, 9);
        chk(sleep_mode, 1);
        tx(40'hAB, 8);
        chk({sleep_mode, standby}, 2'h0);
        repeat (SX) @(negedge clk);
        chk(standby, 1);
        tx(40'h06, 8);
        tx(40'h20000000, 32);
        reset_pin_n = 1'b0;
        repeat (6) @(negedge clk);
        chk({nab[7:0], ndone[7:0], busy_flag, write_unlock_latch}, {8'd1, 8'd5, 2'h0});
        reset_pin_n = 1'b1;
        repeat (10) @(negedge clk);
        tx(40'hB9, 8);
        repeat (SE) @(negedge clk);
        rst = 1'b1;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk({sleep_mode, standby}, 2'h1);
        end_sim();
    end
endmodule : tb_flash_clear_ctrl
`default_nettype wire
